// file: src/aps_pkg.sv
// Shared types and constants for the actuator parameter menu block
package aps_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int TICK_MS      = 100;
  localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int DEB_MS       = 10;
  localparam int DEB_CYC      = CLK_HZ / 1000 * DEB_MS;
  localparam int TAG_MS       = 1000;
  localparam int VER_MS       = 2000;
  localparam int BLINK_MS     = 500;
  localparam int TAG_TICKS    = TAG_MS / TICK_MS;
  localparam int VER_TICKS    = VER_MS / TICK_MS;
  localparam int BLINK_TICKS  = BLINK_MS / TICK_MS;

  // ----------------------------------------------------------------
  // Parameter set: ranges and factory values
  // ----------------------------------------------------------------
  localparam logic [2:0] CABLE_MIN   = 3'h1;
  localparam logic [2:0] CABLE_MAX   = 3'h4;
  localparam logic [2:0] CABLE_RST   = 3'h4;
  localparam logic [6:0] DELAY_MAX   = 7'h63;
  localparam logic [6:0] DELAY_RST   = 7'h00;
  localparam logic [3:0] THR_MAX     = 4'ha;

  // Menu positions, in scroll order
  localparam logic [1:0] SEL_CABLE   = 2'h0;
  localparam logic [1:0] SEL_GDD     = 2'h1;
  localparam logic [1:0] SEL_TED     = 2'h2;
  localparam logic [1:0] SEL_LINK    = 2'h3;

  // ----------------------------------------------------------------
  // Display characters (ASCII)
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_D     = 8'h64;
  localparam logic [7:0] CH_F     = 8'h46;
  localparam logic [7:0] CH_I     = 8'h49;
  localparam logic [7:0] CH_N     = 8'h4e;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_US    = 8'h5f;
  localparam logic [7:0] CH_BLANK = 8'h20;

  // Value arbitrary, stands for the firmware version as two BCD digits
  localparam logic [7:0] FW_VER_BCD = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APS_NEUTRAL,
    APS_FORWARD,
    APS_REVERSE
  } aps_gear_t;

  typedef struct packed {
    aps_gear_t  gear;
    logic [3:0] thr;    // 0 idle, 1..10 minimum to maximum
  } aps_lever_t;

  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } aps_disp_t;

  typedef struct packed {
    logic [2:0] cable_direction_setting;
    logic [6:0] gear_disengage_delay;   // tenths of a second
    logic [6:0] throttle_engage_delay;  // tenths of a second
  } aps_param_t;

endpackage

// file: src/aps_key_filter.sv
// Debounce filter for one key, giving a held level and a press pulse
`timescale 1ns/1ns
module aps_key_filter #(
  parameter int DEB_CYC = 100_000
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic key_in,
  output logic      held_out,
  output logic      press_out
);

  logic [$clog2(DEB_CYC+1)-1:0] cnt_reg;

  // Stable level only follows after the input has held steady
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg  <= '0;
      held_out <= 1'b0;
    end else if (key_in == held_out) begin
      cnt_reg  <= '0;
    end else if (cnt_reg == ($bits(cnt_reg))'(DEB_CYC - 1)) begin
      cnt_reg  <= '0;
      held_out <= key_in;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
    end
  end

  // One pulse per assertion
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      press_out <= 1'b0;
    end else begin
      press_out <= (cnt_reg == ($bits(cnt_reg))'(DEB_CYC - 1)) &&
                   key_in && !held_out;
    end
  end

  single_press_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    press_out |-> held_out && !$past(held_out) ##1 !press_out)
    else $error("key press pulse not single or not on rise");

endmodule

// file: src/aps_menu.sv
// Parameter menu, display and shift delay logic of the actuator
// ----------------------------------------------------------------
// Overview of operation
// - after reset the display shows the firmware tag, then the version, then two underscores 2 s later.
// - UP and DOWN pressed together while idle open the menu at the cable direction setting.
// - in the selection view, UP or DOWN moves the selection to the neighbouring parameter.
// - ENTER shows the selected value blinking, and UP or DOWN then change it, except in the read-only link check view.
// - a second ENTER stores the value, stops blinking at once and returns to selection.
// - the cable direction setting ranges one to four, resets to 4 and shows as two digits.
// - the gear disengage delay ranges zero to 9.9 s and resets to zero.
// - the throttle engage delay ranges zero to 9.9 s and resets to zero, shown as 00.
// - on a lever move from forward or reverse to neutral the gear holds until the disengage delay expires.
// - on a lever move from neutral into gear the throttle stays at idle (0) until the engage delay expires.
// - the link check view shows N, F, R, or 1 to A for throttle, per station.
// - in the link check view the left digit is the left station and the right digit the right one.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module aps_menu
  import aps_pkg::*;
#(
  parameter int TICK_CYC = aps_pkg::TICK_CYC,
  parameter int DEB_CYC  = aps_pkg::DEB_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       key_up_in,
  input  wire logic       key_down_in,
  input  wire logic       key_enter_in,
  input  wire aps_lever_t lever_left_in,
  input  wire aps_lever_t lever_right_in,
  input  wire logic       active_right_in,
  output aps_disp_t       disp_out,
  output logic            disp_blink_out,
  output aps_gear_t       gear_out,
  output logic [3:0]      throttle_out,
  output aps_param_t      params_out
);

  // Tick must leave at least two quiet cycles between pulses
  if (TICK_CYC < 3 || DEB_CYC < 2) begin : g_chk
    $error("aps_menu: TICK_CYC must be at least 3, DEB_CYC at least 2");
  end

  typedef enum logic [2:0] {
    S_TAG, S_VER, S_IDLE, S_SEL, S_EDIT
  } aps_state_t;

  typedef enum logic [1:0] {
    D_STEADY, D_DISENGAGE, D_ENGAGE
  } aps_drv_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic aps_disp_t dec2(input logic [6:0] v);
    aps_disp_t d;
    d.left  = CH_0 + 8'(v / 7'd10);
    d.right = CH_0 + 8'(v % 7'd10);
    return d;
  endfunction

  function automatic logic [7:0] lever_char(input aps_lever_t l);
    logic [7:0] c;
    c = CH_N;
    if (l.gear != APS_NEUTRAL) begin
      if (l.thr == 4'h0) begin
        c = (l.gear == APS_FORWARD) ? CH_F : CH_R;
      end else if (l.thr >= THR_MAX) begin
        c = CH_A;
      end else begin
        c = CH_0 + {4'h0, l.thr};
      end
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Keys
  // ----------------------------------------------------------------
  logic [2:0] key_raw, key_held, key_press;
  assign key_raw = {key_enter_in, key_down_in, key_up_in};

  for (genvar k = 0; k < 3; k++) begin : g_key
    aps_key_filter #(.DEB_CYC(DEB_CYC)) u_filt (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .key_in    (key_raw[k]),
      .held_out  (key_held[k]),
      .press_out (key_press[k])
    );
  end

  // Joint press: either key rises while the other is already down
  logic up_ev, down_ev, enter_ev, combo_ev;
  assign combo_ev = (key_press[0] && key_held[1]) ||
                    (key_press[1] && key_held[0]);
  assign up_ev    = key_press[0] && !key_held[1];
  assign down_ev  = key_press[1] && !key_held[0];
  assign enter_ev = key_press[2];

  // ----------------------------------------------------------------
  // 100 ms tick
  // ----------------------------------------------------------------
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_reg;
  logic                        tick;
  assign tick = (tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYC - 1));

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Menu state machine and parameter store
  // ----------------------------------------------------------------
  aps_state_t state_reg;
  logic [1:0] sel_reg;
  logic [6:0] edit_reg;
  logic [4:0] boot_cnt_reg;
  aps_param_t par_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg    <= S_TAG;
      sel_reg      <= SEL_CABLE;
      edit_reg     <= '0;
      boot_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        S_TAG: if (tick) begin
          if (boot_cnt_reg == 5'(TAG_TICKS - 1)) begin
            boot_cnt_reg <= '0;
            state_reg    <= S_VER;
          end else begin
            boot_cnt_reg <= boot_cnt_reg + 1'b1;
          end
        end
        S_VER: if (tick) begin
          if (boot_cnt_reg == 5'(VER_TICKS - 1)) begin
            state_reg    <= S_IDLE;
          end else begin
            boot_cnt_reg <= boot_cnt_reg + 1'b1;
          end
        end
        S_IDLE: if (combo_ev) begin
          state_reg <= S_SEL;
          sel_reg   <= SEL_CABLE;
        end
        S_SEL: begin
          if (enter_ev) begin
            state_reg <= S_EDIT;
            unique case (sel_reg)
              SEL_CABLE: edit_reg <= {4'h0, par_reg.cable_direction_setting};
              SEL_GDD:   edit_reg <= par_reg.gear_disengage_delay;
              SEL_TED:   edit_reg <= par_reg.throttle_engage_delay;
              SEL_LINK:  edit_reg <= '0;
            endcase
          end else if (up_ev && sel_reg != SEL_CABLE) begin
            sel_reg <= sel_reg - 1'b1;
          end else if (down_ev && sel_reg != SEL_LINK) begin
            sel_reg <= sel_reg + 1'b1;
          end
        end
        S_EDIT: begin
          // Link check view is read only, so UP and DOWN do nothing there
          if (enter_ev) begin
            state_reg <= S_SEL;
          end else if (up_ev && sel_reg != SEL_LINK) begin
            if (edit_reg != ((sel_reg == SEL_CABLE) ? {4'h0, CABLE_MAX}
                                                    : DELAY_MAX)) begin
              edit_reg <= edit_reg + 1'b1;
            end
          end else if (down_ev && sel_reg != SEL_LINK) begin
            if (edit_reg != ((sel_reg == SEL_CABLE) ? {4'h0, CABLE_MIN}
                                                    : 7'h00)) begin
              edit_reg <= edit_reg - 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      par_reg.cable_direction_setting <= CABLE_RST;
      par_reg.gear_disengage_delay    <= DELAY_RST;
      par_reg.throttle_engage_delay   <= DELAY_RST;
    end else if (state_reg == S_EDIT && enter_ev) begin
      unique case (sel_reg)
        SEL_CABLE: par_reg.cable_direction_setting <= edit_reg[2:0];
        SEL_GDD:   par_reg.gear_disengage_delay    <= edit_reg;
        SEL_TED:   par_reg.throttle_engage_delay   <= edit_reg;
        SEL_LINK:  par_reg <= par_reg;
      endcase
    end
  end

  assign params_out = par_reg;

  // ----------------------------------------------------------------
  // Display
  // ----------------------------------------------------------------
  logic      blink_on_reg;
  logic [2:0] blink_cnt_reg;
  aps_disp_t disp_next;

  // Blink restarts on every edit so the first phase is always visible
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      blink_on_reg  <= 1'b1;
      blink_cnt_reg <= '0;
    end else if (state_reg != S_EDIT) begin
      blink_on_reg  <= 1'b1;
      blink_cnt_reg <= '0;
    end else if (tick) begin
      if (blink_cnt_reg == 3'(BLINK_TICKS - 1)) begin
        blink_cnt_reg <= '0;
        blink_on_reg  <= !blink_on_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  always_comb begin
    disp_next = '{CH_US, CH_US};
    unique case (state_reg)
      S_TAG:  disp_next = '{CH_F, CH_I};
      S_VER:  disp_next = '{CH_0 + {4'h0, FW_VER_BCD[7:4]},
                            CH_0 + {4'h0, FW_VER_BCD[3:0]}};
      S_IDLE: disp_next = '{CH_US, CH_US};
      S_SEL: begin
        unique case (sel_reg)
          SEL_CABLE: disp_next = '{CH_A, CH_0};
          SEL_GDD:   disp_next = '{CH_D, CH_I};
          SEL_TED:   disp_next = '{CH_D, CH_A};
          SEL_LINK:  disp_next = '{CH_C, CH_C};
        endcase
      end
      S_EDIT: begin
        if (!blink_on_reg) begin
          disp_next = '{CH_BLANK, CH_BLANK};
        end else if (sel_reg == SEL_LINK) begin
          disp_next = '{lever_char(lever_left_in),
                        lever_char(lever_right_in)};
        end else begin
          disp_next = dec2(edit_reg);
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      disp_out       <= '{CH_BLANK, CH_BLANK};
      disp_blink_out <= 1'b0;
    end else begin
      disp_out       <= disp_next;
      disp_blink_out <= (state_reg == S_EDIT);
    end
  end

  // ----------------------------------------------------------------
  // Shift delays on the active station's lever
  // ----------------------------------------------------------------
  aps_lever_t lev;
  aps_drv_t   drv_reg;
  logic [6:0] dly_reg;
  assign lev = active_right_in ? lever_right_in : lever_left_in;

  // Delay resolution is one tick: expiry may land up to 100 ms early
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drv_reg  <= D_STEADY;
      dly_reg  <= '0;
      gear_out <= APS_NEUTRAL;
    end else begin
      unique case (drv_reg)
        D_STEADY: if (lev.gear != gear_out) begin
          if (gear_out == APS_NEUTRAL) begin
            gear_out <= lev.gear;
            dly_reg  <= par_reg.throttle_engage_delay;
            drv_reg  <= D_ENGAGE;
          end else begin
            dly_reg  <= par_reg.gear_disengage_delay;
            drv_reg  <= D_DISENGAGE;
          end
        end
        D_DISENGAGE: begin
          if (lev.gear == gear_out) begin
            drv_reg  <= D_STEADY;
          end else if (dly_reg == 7'h00) begin
            gear_out <= APS_NEUTRAL;
            drv_reg  <= D_STEADY;
          end else if (tick) begin
            dly_reg  <= dly_reg - 1'b1;
          end
        end
        D_ENGAGE: begin
          if (dly_reg == 7'h00) begin
            drv_reg <= D_STEADY;
          end else if (tick) begin
            dly_reg <= dly_reg - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      throttle_out <= 4'h0;
    end else if (drv_reg == D_STEADY && gear_out != APS_NEUTRAL &&
                 lev.gear == gear_out) begin
      throttle_out <= (lev.thr > THR_MAX) ? THR_MAX : lev.thr;
    end else begin
      throttle_out <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  idle_display_a: assert property (
    state_reg == S_IDLE |=> disp_out == aps_disp_t'{CH_US, CH_US})
    else $error("idle display is not two underscores");

  menu_entry_a: assert property (
    state_reg == S_IDLE && combo_ev |=> state_reg == S_SEL &&
      sel_reg == SEL_CABLE ##1 disp_out == aps_disp_t'{CH_A, CH_0})
    else $error("menu entry does not show the first parameter");

  scroll_down_a: assert property (
    state_reg == S_SEL && down_ev && !enter_ev && sel_reg != SEL_LINK
      |=> sel_reg == $past(sel_reg) + 2'h1)
    else $error("down key did not move to next parameter");

  edit_blink_a: assert property (
    state_reg == S_SEL && enter_ev |=> state_reg == S_EDIT ##1
      disp_blink_out)
    else $error("enter did not start blinking edit");

  store_value_a: assert property (
    state_reg == S_EDIT && enter_ev && sel_reg == SEL_GDD |=>
      par_reg.gear_disengage_delay == $past(edit_reg) &&
      state_reg == S_SEL ##1 !disp_blink_out)
    else $error("enter did not store value and stop blinking");

  cable_range_a: assert property (
    par_reg.cable_direction_setting >= CABLE_MIN &&
    par_reg.cable_direction_setting <= CABLE_MAX)
    else $error("cable direction out of range");

  disengage_range_a: assert property (
    par_reg.gear_disengage_delay <= DELAY_MAX)
    else $error("gear disengage delay out of range");

  engage_range_a: assert property (
    par_reg.throttle_engage_delay <= DELAY_MAX)
    else $error("throttle engage delay out of range");

  gear_hold_a: assert property (
    drv_reg == D_DISENGAGE && dly_reg != 7'h00 |=>
      gear_out == $past(gear_out) && gear_out != APS_NEUTRAL)
    else $error("gear released before disengage delay expired");

  throttle_hold_a: assert property (
    drv_reg == D_ENGAGE |=> throttle_out == 4'h0)
    else $error("throttle rose before engage delay expired");

  link_view_a: assert property (
    state_reg == S_EDIT && sel_reg == SEL_LINK && blink_on_reg |=>
      disp_out.left == lever_char($past(lever_left_in)) &&
      disp_out.right == lever_char($past(lever_right_in)))
    else $error("link check view shows wrong lever states");

  tick_period_a: assert property (
    tick |=> !tick [*2])
    else $error("tick repeats too soon");

  menu_entry_c: cover property (state_reg == S_IDLE && combo_ev);
  store_c:      cover property (state_reg == S_EDIT && enter_ev);
  disengage_c:  cover property (drv_reg == D_DISENGAGE ##1
                                drv_reg == D_STEADY);

endmodule

// file: tb/aps_operator.sv
// Keypad and lever station model for the parameter menu
`timescale 1ns/1ns
module aps_operator
  import aps_pkg::*;
(
  input  wire logic clk_in,
  output logic [2:0] keys_out,
  output aps_lever_t lever_left_out,
  output aps_lever_t lever_right_out
);
  // ------------------------------------------------------------
  // Keys {enter, down, up} and station levers, off the fall
  // ------------------------------------------------------------
  initial begin
    keys_out        = 3'h0;
    lever_left_out  = '{APS_NEUTRAL, 4'h0};
    lever_right_out = '{APS_NEUTRAL, 4'h0};
  end

  // Joint press: first key held alone, then the second joins
  task automatic press(input logic [2:0] k1, input logic [2:0] k2);
    @(negedge clk_in);
    keys_out = k1;
    repeat (6) @(negedge clk_in);
    keys_out = k2;
    repeat (6) @(negedge clk_in);
    keys_out = 3'h0;
    repeat (8) @(negedge clk_in);
  endtask

  // Stations report their lever as a steady level
  task automatic move(input logic r, input aps_gear_t g,
                      input logic [3:0] t);
    @(negedge clk_in);
    if (r)
      lever_right_out = '{g, t};
    else
      lever_left_out = '{g, t};
  endtask
endmodule

// file: tb/aps_menu_test.sv
// Self-checking bench for the parameter menu and shift delays
`timescale 1ns/1ns
module aps_menu_test
  import aps_pkg::*;
;
  localparam int TK = 20;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       active_right_in = 1'b0;
  logic [2:0] keys;
  aps_lever_t lv_l;
  aps_lever_t lv_r;
  aps_disp_t  disp_out;
  logic       disp_blink_out;
  aps_gear_t  gear_out;
  logic [3:0] throttle_out;
  aps_param_t params_out;
  int         mismatches = 0;
  int         n_checks = 0;
  int         cycles = 0;

  always #50 clk_in = ~clk_in;

  aps_operator u_op (.clk_in(clk_in), .keys_out(keys),
    .lever_left_out(lv_l), .lever_right_out(lv_r));
  aps_menu #(.TICK_CYC(TK), .DEB_CYC(3)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .key_up_in(keys[0]),
    .key_down_in(keys[1]), .key_enter_in(keys[2]),
    .lever_left_in(lv_l), .lever_right_in(lv_r),
    .active_right_in(active_right_in), .disp_out(disp_out),
    .disp_blink_out(disp_blink_out), .gear_out(gear_out),
    .throttle_out(throttle_out), .params_out(params_out));

  // ------------------------------------------------------------
  // Shared checking
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Blink blanks alternate phases, so wait for a visible one
  task automatic see(input logic [15:0] exp);
    int i;
    repeat (3) @(negedge clk_in);
    for (i = 0; i < 300 && disp_out.left === CH_BLANK; i++)
      @(negedge clk_in);
    check("display", disp_out, exp);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_boot();
    int n;
    repeat (3) @(negedge clk_in);
    check("reset", disp_out, 16'h2020);
    nrst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check("tag", disp_out, "FI");
    for (n = 0; n < 700 && disp_out !== 16'h3031; n++)
      @(negedge clk_in);
    for (n = 0; n < 700 && disp_out !== "__"; n++)
      @(negedge clk_in);
    check("ver time", 16'(n >= 380 && n <= 420), 16'h0001);
    check("idle", disp_out, "__");
  endtask

  task automatic t_menu();
    u_op.press(3'h1, 3'h3);
    see("A0");
    u_op.press(3'h2, 3'h2);
    see("dI");
    u_op.press(3'h2, 3'h2);
    see("dA");
    u_op.press(3'h2, 3'h2);
    u_op.press(3'h2, 3'h2);
    see("CC");
    repeat (3) u_op.press(3'h1, 3'h1);
    see("A0");
  endtask

  task automatic t_cable();
    u_op.press(3'h4, 3'h4);
    see("04");
    check("blink", disp_blink_out, 16'h0001);
    u_op.press(3'h1, 3'h1);
    see("04");
    repeat (4) u_op.press(3'h2, 3'h2);
    see("01");
    u_op.press(3'h4, 3'h4);
    check("blink", disp_blink_out, 16'h0000);
    see("A0");
    check("cable", params_out.cable_direction_setting, 16'h0001);
  endtask

  task automatic t_delays();
    u_op.press(3'h2, 3'h2);
    u_op.press(3'h4, 3'h4);
    u_op.press(3'h2, 3'h2);
    see("00");
    repeat (2) u_op.press(3'h1, 3'h1);
    u_op.press(3'h4, 3'h4);
    u_op.press(3'h2, 3'h2);
    u_op.press(3'h4, 3'h4);
    see("00");
    repeat (3) u_op.press(3'h1, 3'h1);
    see("03");
    u_op.press(3'h4, 3'h4);
    check("gdd", params_out.gear_disengage_delay, 16'h0002);
    check("ted", params_out.throttle_engage_delay, 16'h0003);
  endtask

  // Expiry may come up to one tick early, so sample before and after that window
  task automatic t_shift();
    u_op.move(1'b0, APS_FORWARD, 4'h5);
    repeat (30) @(negedge clk_in);
    check("gear", gear_out, APS_FORWARD);
    check("thr held", throttle_out, 16'h0000);
    repeat (40) @(negedge clk_in);
    check("thr", throttle_out, 16'h0005);
    u_op.move(1'b0, APS_NEUTRAL, 4'h0);
    repeat (15) @(negedge clk_in);
    check("gear held", gear_out, APS_FORWARD);
    check("thr min", throttle_out, 16'h0000);
    repeat (35) @(negedge clk_in);
    check("gear", gear_out, APS_NEUTRAL);
    active_right_in = 1'b1;
    u_op.move(1'b1, APS_REVERSE, 4'h2);
    repeat (70) @(negedge clk_in);
    check("gear right", gear_out, APS_REVERSE);
    check("thr right", throttle_out, 16'h0002);
    u_op.move(1'b1, APS_NEUTRAL, 4'h0);
  endtask

  task automatic t_link();
    u_op.press(3'h2, 3'h2);
    u_op.press(3'h4, 3'h4);
    see("NN");
    u_op.move(1'b0, APS_REVERSE, 4'h0);
    u_op.move(1'b1, APS_FORWARD, 4'h0);
    see("RF");
    u_op.move(1'b0, APS_FORWARD, 4'ha);
    u_op.move(1'b1, APS_FORWARD, 4'h3);
    see("A3");
    u_op.press(3'h4, 3'h4);
    see("CC");
  endtask

  initial begin
    t_boot();
    t_menu();
    t_cable();
    t_delays();
    t_shift();
    t_link();
    results();
  end
endmodule
